// ===== hw/aub_pkg.sv
// Shared constants and types for the serial port with transmit path and baud measurement
package aub_pkg;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [3:0] A_INT_GLOBAL = 4'h0;
   localparam logic [3:0] A_PER_FLAGS  = 4'h1;
   localparam logic [3:0] A_PER_ENA    = 4'h2;
   localparam logic [3:0] A_PER_PRIO   = 4'h3;
   localparam logic [3:0] A_RX_STAT    = 4'h4;
   localparam logic [3:0] A_TX_BUF     = 4'h5;
   localparam logic [3:0] A_TX_STAT    = 4'h6;
   localparam logic [3:0] A_BAUD_CTL   = 4'h7;
   localparam logic [3:0] A_DIV_HI     = 4'h8;
   localparam logic [3:0] A_DIV_LO     = 4'h9;
   localparam logic [3:0] A_RX_BUF     = 4'hA;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int unsigned B_RX_FLAG   = 5;
   localparam int unsigned B_TX_FLAG   = 4;
   localparam int unsigned B_PORT_EN   = 7;
   localparam int unsigned B_CSRC      = 7;
   localparam int unsigned B_TX9       = 6;
   localparam int unsigned B_TRANSMIT_ENABLE      = 5;
   localparam int unsigned B_SYNC      = 4;
   localparam int unsigned B_SENDB     = 3;
   localparam int unsigned B_HISPEED   = 2;
   localparam int unsigned B_SR_EMPTY  = 1;
   localparam int unsigned B_NINTH_TRANSMIT_BIT      = 0;
   localparam int unsigned B_OVF       = 7;
   localparam int unsigned B_SCKP      = 4;
   localparam int unsigned B_WIDE      = 3;
   localparam int unsigned B_WAKE      = 1;
   localparam int unsigned B_ABD_EN    = 0;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0]  RST_BYTE    = 8'h00;
   localparam logic [15:0] RST_DIV     = 16'h0000;

   // ************************************************************
   // Counts
   // ************************************************************
   localparam int unsigned PRE_SLOW    = 64;
   localparam int unsigned PRE_MID     = 16;
   localparam int unsigned PRE_FAST    = 4;
   localparam int unsigned ABD_SCALE   = 8;
   localparam int unsigned ABD_EDGES   = 5;
   localparam logic [3:0]  FRAME_9BIT  = 4'hA;
   localparam logic [3:0]  FRAME_8BIT  = 4'h9;
   localparam logic [15:0] DIV_MAX     = 16'hFFFF;

   typedef enum logic [2:0] {
      AB_OFF,
      AB_BREAK,
      AB_START,
      AB_FIRST,
      AB_COUNT
   } aub_ab_t;

endpackage

// ===== hw/aub_tx_if.sv
// Link between the register core and the transmit shifter
`timescale 1ns/1ps
interface aub_tx_if;
   logic       run;
   logic       tick;
   logic       load;
   logic [8:0] data;
   logic       nine;
   logic       idle;
   logic       line;

   modport ctl (output run, output tick, output load, output data, output nine,
                input idle, input line);
   modport sh  (input run, input tick, input load, input data, input nine,
                output idle, output line);
endinterface

// ===== hw/aub_sync.sv
// Three-stage synchroniser with agreement filter for an outside pin
`timescale 1ns/1ps
module aub_sync (
   input  wire logic mclk_i,   // Clock
   input  wire logic rst_i,    // Async reset, high
   input  wire logic pin_i,    // Raw pin
   output logic      level_o   // Filtered level
);

   typedef struct packed {
      logic [2:0] ff;
      logic       lvl;
   } aub_sync_st_t;

   aub_sync_st_t q;
   aub_sync_st_t d;

   always_comb begin
      d = q;
      d.ff = {q.ff[1:0], pin_i};
      // First stage feeds only the second
      if (q.ff[1] == q.ff[2]) begin
         d.lvl = q.ff[2];
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '{ff: 3'h7, lvl: 1'b1};
      end else begin
         q <= d;
      end
   end

   assign level_o = q.lvl;
endmodule

// ===== hw/aub_tx.sv
// Transmit shift register: start, data LSB first, optional ninth bit, stop
`timescale 1ns/1ps
module aub_tx (
   input  wire logic mclk_i,   // Clock
   input  wire logic rst_i,    // Async reset, high
   aub_tx_if.sh      t         // Shifter side of link
);

   typedef struct packed {
      logic [9:0] sh;
      logic [3:0] left;
      logic       busy;
      logic       line;
   } aub_tx_st_t;

   aub_tx_st_t q;
   aub_tx_st_t d;

   always_comb begin
      d = q;
      if (!t.run) begin
         d.busy = 1'b0;
         d.line = 1'b1;
         d.left = 4'h0;
      end else if (t.load && !q.busy) begin
         d.busy = 1'b1;
         d.line = 1'b0;                                    // RULE_23
         d.sh   = t.nine ? {1'b1, t.data} : {2'b11, t.data[7:0]}; // RULE_24
         d.left = t.nine ? aub_pkg::FRAME_9BIT : aub_pkg::FRAME_8BIT; // RULE_12
      end else if (q.busy && t.tick) begin
         if (q.left == 4'h0) begin
            d.busy = 1'b0;                                 // RULE_16
         end else begin
            d.line = q.sh[0];                              // RULE_13
            d.sh   = {1'b1, q.sh[9:1]};
            d.left = q.left - 4'h1;
         end
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '{sh: 10'h3FF, left: 4'h0, busy: 1'b0, line: 1'b1};
      end else begin
         q <= d;
      end
   end

   assign t.idle = ~q.busy;
   assign t.line = q.line;

   start_low_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_23
      (t.run && t.load && !q.busy) |=> (!q.line && q.busy))
      else $error("start bit not driven low after load");

   idle_high_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_23
      !q.busy |-> q.line)
      else $error("idle line not high");

   stop_end_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_16
      (t.run && q.busy && t.tick && q.left == 4'h0) |=> (!q.busy && q.line))
      else $error("shifter not empty after stop bit");
endmodule

// ===== hw/aub_top.sv
// Serial port core: registers, baud generator, baud measurement, transmit buffer
//
// Notes on behaviour
// RULE_01: Measure only in async mode, wake clear.
// RULE_02: Enable clears counter, then awaits start bit.
// RULE_03: Remote sends 55h calibration character.
// RULE_04: Count from first rise; fifth rise ends.
// RULE_05: Rollover sets sticky overflow; measurement continues.
// RULE_06: Counter runs at one eighth baud clock.
// RULE_07: Counter clock osc/512, /128 or /32.
// RULE_08: Both divider bytes count as 16 bits.
// RULE_09: Receiver held idle; flag set at end.
// RULE_10: With wake enable, measure after break.
// RULE_11: No buffer writes while measuring.
// RULE_12: Async frame: start, 8/9 data, stop.
// RULE_13: LSB first; shared format and rate.
// RULE_14: Baud clock sixteen or sixty-four times; code also uses four times when wide and high speed are both set.
// RULE_15: No hardware parity; ninth bit from software.
// RULE_16: Shifter reloads only after stop bit.
// RULE_17: One-cycle transfer sets buffer-empty flag.
// RULE_18: Empty flag ignores enable, not writable.
// RULE_19: Empty flag valid two cycles after load.
// RULE_20: Shifter-empty bit readable, no interrupt.
// RULE_21: Transmit enable sets buffer-empty flag.
// RULE_22: Setup first; buffer write starts sending.
// RULE_23: Line idles high, start low, stop high.
// RULE_24: Ninth bit after bit 7, before stop.
`timescale 1ns/1ps
module aub_top #(
   parameter int unsigned EDGE_COUNT = aub_pkg::ABD_EDGES  // Rising edges per measurement
) (
   input  wire logic       mclk_i,     // Oscillator clock
   input  wire logic       rst_i,      // Async reset, high
   input  wire logic [3:0] addr_i,     // Register address
   input  wire logic [7:0] wdata_i,    // Write data
   input  wire logic       wr_i,       // Write strobe
   input  wire logic       rd_i,       // Read strobe
   output logic      [7:0] rdata_o,    // Read data, cycle after strobe
   input  wire logic       rx_i,       // Receive pin
   input  wire logic       rx_done_i,  // Receiver finished a character
   input  wire logic [7:0] rx_data_i,  // Receiver data byte
   output logic            rx_hold_o,  // Hold receiver idle
   output logic            tx_o        // Transmit pin
);

   // ************************************************************
   // Parameter check
   // ************************************************************
   if (EDGE_COUNT < 2 || EDGE_COUNT > 7) begin : g_bad_edges
      $error("EDGE_COUNT must lie in 2..7");
   end

   localparam logic [2:0] EDGE_LAST = 3'(EDGE_COUNT - 1);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [7:0]      interrupt_global_control;
      logic [7:0]      pflags;
      logic [7:0]      pena;
      logic [7:0]      pprio;
      logic            port_enable;
      logic [6:0]      rxs_lo;
      logic [7:0]      txbuf;
      logic            txfull;
      logic            txflag;
      logic            csrc;
      logic            tx9;
      logic            transmit_enable;
      logic            sync;
      logic            sendb;
      logic            high_speed_select;
      logic            ninth_transmit_bit;
      logic            ovf;
      logic            sckp;
      logic            wide_divider_select;
      logic            wake_on_break_enable;
      logic            autobaud_enable;
      logic [15:0]     div;
      logic [8:0]      pre;
      logic [15:0]     bcnt;
      aub_pkg::aub_ab_t ab;
      logic [2:0]      edges;
      logic            rxl;
      logic            rcflag;
      logic [7:0]      rdata;
      logic            hold;
      logic            load;
      logic            tick;
      logic [8:0]      ldata;
      logic            lnine;
   } aub_top_st_t;

   aub_top_st_t q;
   aub_top_st_t d;

   logic       rx_lvl;
   logic       rise;
   logic       fall;
   logic       meas;
   logic [8:0] lim;
   logic [15:0] div_sel;
   logic       set_rc;
   logic       set_ovf;

   aub_tx_if txl ();

   aub_sync u_rx_sync (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .pin_i   (rx_i),
      .level_o (rx_lvl)
   );

   aub_tx u_tx (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .t      (txl.sh)
   );

   // Prescale limit: bit period uses PRE, measurement uses eight times PRE
   function automatic logic [8:0] pre_limit(input logic wide, input logic fast,
                                             input logic m);
      int unsigned p;
      p = (wide && fast) ? aub_pkg::PRE_FAST :
          (wide || fast) ? aub_pkg::PRE_MID  : aub_pkg::PRE_SLOW;  // RULE_14
      if (m) begin
         p = p * aub_pkg::ABD_SCALE;                                 // RULE_06
      end
      return 9'(p - 1);
   endfunction

   assign rise    = rx_lvl & ~q.rxl;
   assign fall    = ~rx_lvl & q.rxl;
   assign meas    = (q.ab == aub_pkg::AB_COUNT);
   assign lim     = pre_limit(q.wide_divider_select, q.high_speed_select, meas);                // RULE_07
   assign div_sel = q.wide_divider_select ? q.div : {8'h00, q.div[7:0]};

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      d       = q;
      d.load  = 1'b0;
      d.tick  = 1'b0;
      d.rdata = aub_pkg::RST_BYTE;
      d.rxl   = rx_lvl;
      set_rc  = 1'b0;
      set_ovf = 1'b0;

      // Measurement sequence; frozen in clocked mode
      if (!q.sync) begin                                             // RULE_01
         case (q.ab)
            aub_pkg::AB_OFF: begin
            end
            aub_pkg::AB_BREAK: begin
               if (rise) begin                                       // RULE_10
                  d.wake_on_break_enable = 1'b0;
                  d.ab  = aub_pkg::AB_START;
               end
            end
            aub_pkg::AB_START: begin
               if (fall && !q.wake_on_break_enable) begin                             // RULE_02
                  d.ab = aub_pkg::AB_FIRST;
               end
            end
            aub_pkg::AB_FIRST: begin
               if (rise) begin                                       // RULE_04
                  d.ab    = aub_pkg::AB_COUNT;
                  d.edges = 3'h1;
                  d.pre   = 9'h000;
               end
            end
            aub_pkg::AB_COUNT: begin
               // Relies on a 55h character for edge spacing          // RULE_03
               if (rise) begin
                  if (q.edges == EDGE_LAST) begin                    // RULE_04
                     d.ab    = aub_pkg::AB_OFF;
                     d.autobaud_enable = 1'b0;
                     set_rc  = 1'b1;                                 // RULE_09
                  end else begin
                     d.edges = q.edges + 3'h1;
                  end
               end
            end
            default: begin
               d.ab = aub_pkg::AB_OFF;
            end
         endcase
      end

      // ************************************************************
      // Baud generator
      // ************************************************************
      if (meas) begin
         if (q.pre == lim) begin
            d.pre = 9'h000;
            d.div = q.div + 16'h0001;                                // RULE_08
            if (q.div == aub_pkg::DIV_MAX) begin
               set_ovf = 1'b1;                                       // RULE_05
            end
         end else begin
            d.pre = q.pre + 9'h001;
         end
      end else if (txl.idle && !q.load) begin
         // Restart so the start bit gets a full period
         d.pre  = 9'h000;
         d.bcnt = 16'h0000;
      end else if (q.pre == lim) begin
         d.pre = 9'h000;
         if (q.bcnt == div_sel) begin
            d.bcnt = 16'h0000;
            d.tick = 1'b1;                                           // RULE_13
         end else begin
            d.bcnt = q.bcnt + 16'h0001;
         end
      end else begin
         d.pre = q.pre + 9'h001;
      end

      // ************************************************************
      // Buffer to shifter transfer
      // ************************************************************
      if (q.txfull && txl.idle && !q.load && q.transmit_enable && q.port_enable && !q.sync
          && !q.autobaud_enable) begin                                         // RULE_16
         d.load   = 1'b1;                                            // RULE_17
         d.ldata  = {q.ninth_transmit_bit, q.txbuf};                               // RULE_15
         d.lnine  = q.tx9;
         d.txfull = 1'b0;
      end

      // ************************************************************
      // Register writes
      // ************************************************************
      if (wr_i) begin
         case (addr_i)
            aub_pkg::A_INT_GLOBAL: d.interrupt_global_control = wdata_i;
            aub_pkg::A_PER_FLAGS:  d.pflags = wdata_i;               // RULE_18
            aub_pkg::A_PER_ENA:    d.pena   = wdata_i;
            aub_pkg::A_PER_PRIO:   d.pprio  = wdata_i;
            aub_pkg::A_RX_STAT: begin
               d.port_enable   = wdata_i[aub_pkg::B_PORT_EN];
               d.rxs_lo = wdata_i[6:0];
            end
            aub_pkg::A_TX_BUF: begin
               if (!q.autobaud_enable) begin                                   // RULE_11
                  d.txbuf  = wdata_i;
                  d.txfull = 1'b1;                                   // RULE_22
               end
            end
            aub_pkg::A_TX_STAT: begin
               d.csrc  = wdata_i[aub_pkg::B_CSRC];
               d.tx9   = wdata_i[aub_pkg::B_TX9];
               d.transmit_enable  = wdata_i[aub_pkg::B_TRANSMIT_ENABLE];
               d.sync  = wdata_i[aub_pkg::B_SYNC];
               d.sendb = wdata_i[aub_pkg::B_SENDB];
               d.high_speed_select  = wdata_i[aub_pkg::B_HISPEED];
               d.ninth_transmit_bit  = wdata_i[aub_pkg::B_NINTH_TRANSMIT_BIT];
               if (wdata_i[aub_pkg::B_TRANSMIT_ENABLE] && !q.transmit_enable) begin
                  d.txfull = 1'b0;                                   // RULE_21
               end
            end
            aub_pkg::A_BAUD_CTL: begin
               d.ovf   = wdata_i[aub_pkg::B_OVF];                    // RULE_05
               d.sckp  = wdata_i[aub_pkg::B_SCKP];
               d.wide_divider_select = wdata_i[aub_pkg::B_WIDE];
               d.wake_on_break_enable   = wdata_i[aub_pkg::B_WAKE];
               d.autobaud_enable = wdata_i[aub_pkg::B_ABD_EN];
               if (wdata_i[aub_pkg::B_ABD_EN] && !q.autobaud_enable) begin
                  d.div = aub_pkg::RST_DIV;                          // RULE_02
                  d.ab  = wdata_i[aub_pkg::B_WAKE] ? aub_pkg::AB_BREAK
                                                   : aub_pkg::AB_START; // RULE_10
               end else if (!wdata_i[aub_pkg::B_ABD_EN]) begin
                  d.ab = aub_pkg::AB_OFF;
               end
            end
            aub_pkg::A_DIV_HI: d.div[15:8] = wdata_i;
            aub_pkg::A_DIV_LO: d.div[7:0]  = wdata_i;
            default: begin
            end
         endcase
      end

      // Hardware sets win over software clears
      if (set_ovf) begin
         d.ovf = 1'b1;                                               // RULE_05
      end
      if (rd_i && addr_i == aub_pkg::A_RX_BUF) begin
         d.rcflag = 1'b0;                                            // RULE_09
      end
      if (set_rc || rx_done_i) begin
         d.rcflag = 1'b1;
      end

      // Lags the buffer state by one cycle
      d.txflag = ~q.txfull;                                          // RULE_19
      d.hold   = (d.ab != aub_pkg::AB_OFF);                          // RULE_09

      // ************************************************************
      // Register reads
      // ************************************************************
      if (rd_i) begin
         case (addr_i)
            aub_pkg::A_INT_GLOBAL: d.rdata = q.interrupt_global_control;
            aub_pkg::A_PER_FLAGS:  d.rdata = {q.pflags[7:6], q.rcflag, q.txflag,
                                              q.pflags[3:0]};        // RULE_18
            aub_pkg::A_PER_ENA:    d.rdata = q.pena;
            aub_pkg::A_PER_PRIO:   d.rdata = q.pprio;
            aub_pkg::A_RX_STAT:    d.rdata = {q.port_enable, q.rxs_lo};
            aub_pkg::A_TX_BUF:     d.rdata = q.txbuf;
            aub_pkg::A_TX_STAT:    d.rdata = {q.csrc, q.tx9, q.transmit_enable, q.sync, q.sendb,
                                              q.high_speed_select, txl.idle, q.ninth_transmit_bit}; // RULE_20
            aub_pkg::A_BAUD_CTL:   d.rdata = {q.ovf, 2'b00, q.sckp, q.wide_divider_select, 1'b0,
                                              q.wake_on_break_enable, q.autobaud_enable};
            aub_pkg::A_DIV_HI:     d.rdata = q.div[15:8];
            aub_pkg::A_DIV_LO:     d.rdata = q.div[7:0];
            aub_pkg::A_RX_BUF:     d.rdata = rx_data_i;
            default:               d.rdata = aub_pkg::RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         q        <= '0;
         q.rxl    <= 1'b1;
         q.ab     <= aub_pkg::AB_OFF;
      end else begin
         q <= d;
      end
   end

   assign txl.run  = q.transmit_enable & q.port_enable & ~q.sync;                      // RULE_12
   assign txl.tick = q.tick;
   assign txl.load = q.load;
   assign txl.data = q.ldata;
   assign txl.nine = q.lnine;
   assign rdata_o   = q.rdata;
   assign rx_hold_o = q.hold;
   assign tx_o      = txl.line;

   // ************************************************************
   // Checks
   // ************************************************************
   abd_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_02
      (wr_i && addr_i == aub_pkg::A_BAUD_CTL && wdata_i[aub_pkg::B_ABD_EN] && !q.autobaud_enable)
      |=> (q.div == 16'h0000 && q.ab != aub_pkg::AB_COUNT))
      else $error("counter not cleared when measurement armed");

   abd_done_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_04
      (meas && rise && !q.sync && q.edges == EDGE_LAST && !wr_i)
      |=> (!q.autobaud_enable && q.rcflag && q.ab == aub_pkg::AB_OFF))
      else $error("measurement did not end at last rising edge");

   abd_ovf_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_05
      (meas && q.pre == lim && q.div == 16'hFFFF && !wr_i && !rise)
      |=> (q.ovf && q.autobaud_enable && q.div == 16'h0000))
      else $error("rollover not trapped or measurement stopped");

   abd_rate_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_07
      ($past(meas) && !$past(q.wide_divider_select) && !$past(q.high_speed_select) && !$past(wr_i)
       && $changed(q.div)) |-> ($past(q.pre) == 9'h1FF))
      else $error("slow measurement clock not osc/512");

   abd_step_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_08
      (meas && q.pre == lim && !wr_i) |=> (q.div == $past(q.div) + 16'h0001))
      else $error("divider pair did not step as one counter");

   abd_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_09
      meas |=> (rx_hold_o || !q.autobaud_enable))
      else $error("receiver not held idle during measurement");

   flag_late_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_19
      (wr_i && addr_i == aub_pkg::A_TX_BUF && !q.autobaud_enable) |-> ##2 !q.txflag)
      else $error("buffer empty flag still set two cycles after load");

   transmit_enable_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_21
      $rose(q.transmit_enable) |=> q.txflag)
      else $error("transmit enable did not set buffer empty flag");

   xfer_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RULE_17
      (q.load && !$past(wr_i)) |=> q.txflag)
      else $error("transfer did not empty buffer");
endmodule

// ===== verification/aub_node.sv
// Remote serial node: sends a calibration character, captures frames from the line
`timescale 1ns/1ps
module aub_node #(
   parameter int TPER = 40,   // Cycles per bit on the transmit line
   parameter int RPER = 320   // Cycles per bit sent to the receive pin
) (
   input  wire logic        mclk_i,   // Clock
   input  wire logic        tx_i,     // Line from the block
   input  wire logic        go_i,     // Start the calibration character
   output logic             rx_o,     // Line to the block, idles high
   output logic      [10:0] frame_o,  // Captured bits, start in bit 0
   output int               nfr_o     // Frames captured
);
   logic [9:0] cal;
   initial begin
      rx_o    = 1'b1;
      frame_o = 11'h000;
      nfr_o   = 0;
      cal     = {1'b1, 8'h55, 1'b0};
   end
   always @(posedge go_i) begin
      for (int i = 0; i < 10; i++) begin
         @(posedge mclk_i);
         rx_o <= cal[i];
         repeat (RPER - 1) @(posedge mclk_i);
      end
   end
   // Samples mid-bit so a slip of a few cycles still decodes
   always begin
      @(negedge tx_i);
      repeat (TPER / 2) @(posedge mclk_i);
      for (int i = 0; i < 11; i++) begin
         frame_o[i] = tx_i;
         if (i < 10) repeat (TPER) @(posedge mclk_i);
      end
      nfr_o++;
   end
endmodule

// ===== verification/async_uart_tx_autobaud_tb_top.sv
// Testbench for the serial port core
`timescale 1ns/1ps
module async_uart_tx_autobaud_tb_top;
   logic        mclk_i = 1'b0;
   logic        rst_i  = 1'b1;
   logic [3:0]  addr   = 4'h0;
   logic [7:0]  wdata  = 8'h00;
   logic        wr     = 1'b0;
   logic        rd     = 1'b0;
   logic        go     = 1'b0;
   logic [7:0]  rdata;
   logic [7:0]  d;
   logic        hold;
   logic        tx;
   logic        rx;
   logic [10:0] frame;
   int          nfr;
   int          err_total = 0;
   int          total_checks = 0;
   always #50 mclk_i = ~mclk_i;
   aub_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .rx_i(rx), .rx_done_i(1'b0), .rx_data_i(8'h5A),
      .rx_hold_o(hold), .tx_o(tx));
   aub_node node (.mclk_i(mclk_i), .tx_i(tx), .go_i(go), .rx_o(rx), .frame_o(frame),
      .nfr_o(nfr));
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge mclk_i);
      addr <= a; wdata <= v; wr <= 1'b1;
      @(posedge mclk_i);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge mclk_i);
      addr <= a; rd <= 1'b1;
      @(posedge mclk_i);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wait_frames(input int n);
      for (int i = 0; i < 3000 && nfr < n; i++) @(posedge mclk_i);
      if (nfr < n) err_total++;
   endtask
   task automatic wait_hold();
      for (int i = 0; i < 5000 && hold !== 1'b0; i++) @(posedge mclk_i);
      if (hold !== 1'b0) err_total++;
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic t_reset();
      chk("tx idle", 16'h1, 16'(tx));
      rd_reg(aub_pkg::A_TX_STAT); chk("sr empty", 16'h1, 16'(d[1]));
      rd_reg(aub_pkg::A_PER_FLAGS); chk("flag idle", 16'h1, 16'(d[4]));
   endtask
   task automatic t_tx();
      wr_reg(aub_pkg::A_RX_STAT, 8'h80);
      wr_reg(aub_pkg::A_DIV_LO, 8'h09);
      wr_reg(aub_pkg::A_BAUD_CTL, 8'h08);
      wr_reg(aub_pkg::A_TX_BUF, 8'hFF);
      rd_reg(aub_pkg::A_PER_FLAGS); chk("flag loaded", 16'h0, 16'(d[4]));
      wr_reg(aub_pkg::A_TX_STAT, 8'h65);
      rd_reg(aub_pkg::A_PER_FLAGS); chk("flag on", 16'h1, 16'(d[4]));
      wr_reg(aub_pkg::A_PER_FLAGS, 8'h00);
      rd_reg(aub_pkg::A_PER_FLAGS); chk("flag kept", 16'h1, 16'(d[4]));
      wr_reg(aub_pkg::A_TX_BUF, 8'hA5);
      wr_reg(aub_pkg::A_TX_BUF, 8'h3C);
      rd_reg(aub_pkg::A_PER_FLAGS); chk("flag full", 16'h0, 16'(d[4]));
      rd_reg(aub_pkg::A_TX_STAT); chk("sr busy", 16'h0, 16'(d[1]));
      wait_frames(1); chk("frame1", 16'({2'b11, 8'hA5, 1'b0}), 16'(frame));
      wait_frames(2); chk("frame2", 16'({2'b11, 8'h3C, 1'b0}), 16'(frame));
      rd_reg(aub_pkg::A_PER_FLAGS); chk("flag empty", 16'h1, 16'(d[4]));
   endtask
   task automatic t_abd();
      for (int i = 0; i < 200 && d[1] !== 1'b1; i++) rd_reg(aub_pkg::A_TX_STAT);
      chk("sr idle", 16'h1, 16'(d[1]));
      wr_reg(aub_pkg::A_BAUD_CTL, 8'h09);
      repeat (3) @(posedge mclk_i);
      chk("hold on", 16'h1, 16'(hold));
      rd_reg(aub_pkg::A_DIV_LO); chk("div clear", 16'h0, 16'(d));
      go <= 1'b1;
      wait_hold();
      rd_reg(aub_pkg::A_BAUD_CTL); chk("abd off", 16'h0, 16'(d[0]));
      rd_reg(aub_pkg::A_DIV_HI); chk("div hi", 16'h0, 16'(d));
      // Eight bits of 320 cycles at one count per 32 cycles
      rd_reg(aub_pkg::A_DIV_LO); chk("div lo", 16'h1, 16'(d >= 79 && d <= 81));
      rd_reg(aub_pkg::A_PER_FLAGS); chk("rx flag", 16'h1, 16'(d[5]));
      rd_reg(aub_pkg::A_RX_BUF); chk("rx buf", 16'h5A, 16'(d));
      rd_reg(aub_pkg::A_PER_FLAGS); chk("rx flag clr", 16'h0, 16'(d[5]));
   endtask
   task automatic t_ovf();
      go <= 1'b0;
      wr_reg(aub_pkg::A_TX_STAT, 8'h61);
      wr_reg(aub_pkg::A_BAUD_CTL, 8'h01);
      wr_reg(aub_pkg::A_DIV_HI, 8'hFF);
      wr_reg(aub_pkg::A_DIV_LO, 8'hFE);
      // Node must finish its previous character before it sees a new go edge
      repeat (400) @(posedge mclk_i);
      go <= 1'b1;
      wait_hold();
      // Five counts of 512 cycles from FFFEh wrap once
      rd_reg(aub_pkg::A_BAUD_CTL); chk("ovf end", 16'h80, 16'(d));
      rd_reg(aub_pkg::A_DIV_HI); chk("ovf hi", 16'h0, 16'(d));
      rd_reg(aub_pkg::A_DIV_LO); chk("ovf lo", 16'h1, 16'(d >= 2 && d <= 4));
      wr_reg(aub_pkg::A_BAUD_CTL, 8'h00);
      rd_reg(aub_pkg::A_BAUD_CTL); chk("ovf clr", 16'h0, 16'(d));
   endtask
   initial begin
      repeat (20000) @(posedge mclk_i);
      err_total++;
      print_verdict();
   end
   initial begin
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      t_reset();
      t_tx();
      t_abd();
      t_ovf();
      print_verdict();
   end
endmodule
